// [verilog/tiop_pkg.sv]
// Constants, types and helpers shared by the timed I/O port unit
package tiop_pkg;
  // ----------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------
  localparam int NPORT = 5;   // Ports of width 1, 4, 8, 16, 32
  localparam int NCLKB = 6;   // Clock blocks per tile
  localparam int NPIN  = 32;  // Pins shared by all ports
  localparam int XW    = 32;  // Transfer register width
  localparam int CW    = 16;  // Port counter width
  // ----------------------------------------------------------
  // Address map (byte addresses)
  // ----------------------------------------------------------
  localparam int         GLB_BIT   = 8;       // Set for global registers
  localparam logic [8:0] ADDR_LINK = 9'h100;  // Link pin mask
  localparam logic [8:0] ADDR_CLKB = 9'h120;  // Clock block 0, then +4 each
  localparam logic [1:0] KIND_NONE = 2'h0;
  localparam logic [1:0] KIND_PORT = 2'h1;
  localparam logic [1:0] KIND_LINK = 2'h2;
  localparam logic [1:0] KIND_CLKB = 2'h3;
  // Per-port word index inside a 0x20 stride
  localparam logic [2:0] REG_CTRL  = 3'h0;
  localparam logic [2:0] REG_DATA  = 3'h1;
  localparam logic [2:0] REG_COND  = 3'h2;
  localparam logic [2:0] REG_TIME  = 3'h3;
  localparam logic [2:0] REG_COUNT = 3'h4;
  localparam logic [2:0] REG_STAMP = 3'h5;
  localparam logic [2:0] REG_STAT  = 3'h6;
  // ----------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------
  localparam int          CTRL_EN   = 0;       // Port enable
  localparam int          CTRL_OUT  = 1;       // 1 output, 0 input
  localparam int          CTRL_OD   = 2;       // Open-drain output
  localparam int          CTRL_CLK  = 4;       // Clock block select, 3 bits
  localparam int          CTRL_COND = 8;       // Sample condition, 2 bits
  localparam int          CTRL_STB  = 11;      // Qualify input by strobe
  localparam int          CTRL_W    = 12;
  localparam logic [11:0] CTRL_RST  = 12'h000; // Clock block 0 after reset
  localparam int          CB_EXT    = 0;       // Source is the 1-bit port
  localparam int          CB_DIV    = 8;       // Divider field
  localparam int          CB_DIV_W  = 8;
  localparam int          STAT_FULL = 0;
  localparam int          STAT_BUSY = 1;
  // ----------------------------------------------------------
  // Timing
  // ----------------------------------------------------------
  localparam int         SYS_MHZ  = 100;                // Core clock
  localparam int         REF_MHZ  = 100;                // Reference clock
  localparam int         REF_CYC  = SYS_MHZ / REF_MHZ;  // Cycles per ref tick
  localparam logic [7:0] REF_LAST = 8'(REF_CYC - 1);
  // ----------------------------------------------------------
  // Types
  // ----------------------------------------------------------
  typedef enum logic [1:0] {PH_IDLE = 2'h0, PH_WAIT = 2'h1, PH_SHIFT = 2'h3} tiop_phase_t;
  typedef enum logic [1:0] {COND_NONE = 2'h0, COND_EQ = 2'h1, COND_NEQ = 2'h2} tiop_cond_t;
  // ----------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------
  function automatic int port_w(input int idx);
    case (idx)
      0:       port_w = 1;
      1:       port_w = 4;
      2:       port_w = 8;
      3:       port_w = 16;
      default: port_w = 32;
    endcase
  endfunction
  function automatic logic [XW-1:0] port_mask(input int idx);
    port_mask = (port_w(idx) == XW) ? 32'hFFFF_FFFF : XW'((33'h1 << port_w(idx)) - 33'h1);
  endfunction
  function automatic logic [5:0] port_chunks(input int idx);
    port_chunks = 6'(XW / port_w(idx));
  endfunction
endpackage

// [verilog/tiop_clkblk.sv]
// Clock block: reference or divided external tick generator
`timescale 1ns/1ns
module tiop_clkblk
  import tiop_pkg::*;
#(
  parameter bit FIXED_REF = 1'b0  // Block tied to the reference clock
)
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Configuration
  input  wire logic       i_use_ext,  // Take edges from the 1-bit port
  input  wire logic [7:0] i_div,      // Tick every i_div+1 edges
  // Source and result
  input  wire logic       i_ext_lvl,  // Synchronised 1-bit port level
  output logic            o_tick      // One-cycle pacing pulse
);
  typedef struct packed {
    logic       prev;  // Last external level
    logic [7:0] cnt;   // Cycle or edge count
    logic       tick;  // Registered tick
  } tiop_cb_st_t;

  tiop_cb_st_t st;     // Current state
  tiop_cb_st_t next_st;  // Next state

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  // Rising edges are found on an already synchronised level, so
  // an external tick is never closer than two cycles apart
  always_comb
  begin
    next_st      = st;
    next_st.tick = 1'b0;
    next_st.prev = i_ext_lvl;
    if (FIXED_REF || !i_use_ext)
    begin
      // Reference pacing
      if (st.cnt >= REF_LAST)
      begin
        next_st.cnt  = 8'h00;
        next_st.tick = 1'b1;
      end
      else
        next_st.cnt = st.cnt + 8'h01;
    end
    else if (i_ext_lvl && !st.prev)
    begin
      // External edge, optionally divided
      if (st.cnt >= i_div)
      begin
        next_st.cnt  = 8'h00;
        next_st.tick = 1'b1;
      end
      else
        next_st.cnt = st.cnt + 8'h01;
    end
  end

  // State register
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_tick = st.tick;

  property p_ext_spaced;
    @(posedge i_clk) disable iff (i_rst)
    (!FIXED_REF && i_use_ext && $past(i_use_ext) && o_tick) |=> !o_tick;
  endproperty
  a_ext_spaced:
    assert property (p_ext_spaced) else $error("External ticks back to back");

  property p_ref_rate;
    @(posedge i_clk) disable iff (i_rst)
    ((FIXED_REF || !i_use_ext) && $past(FIXED_REF || !i_use_ext) && !$past(i_rst)) |-> o_tick;
  endproperty
  a_ref_rate:
    assert property (p_ref_rate) else $error("Reference tick missing");
endmodule

// [verilog/tiop_top.sv]
// Timed I/O port unit with clock blocks behind an AHB-Lite slave
`timescale 1ns/1ns
module tiop_top
  import tiop_pkg::*;
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // AHB-Lite slave
  input  wire logic             i_hsel,
  input  wire logic [31:0]      i_haddr,
  input  wire logic [1:0]       i_htrans,
  input  wire logic             i_hwrite,
  input  wire logic [2:0]       i_hsize,
  input  wire logic [31:0]      i_hwdata,
  input  wire logic             i_hready,
  output logic                  o_hreadyout,
  output logic                  o_hresp,
  output logic [31:0]           o_hrdata,
  // Pins
  input  wire logic [NPIN-1:0]  i_pin_in,
  output logic [NPIN-1:0]       o_pin_out,
  output logic [NPIN-1:0]       o_pin_oe,
  output logic [NPIN-1:0]       o_pin_pulldown,
  // Strobes
  input  wire logic [NPORT-1:0] i_strobe_in,
  output logic [NPORT-1:0]      o_strobe_out,
  // Events to the scheduler
  output logic [NPORT-1:0]      o_event
);
  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;     // Port control
    logic [XW-1:0]     xfer;     // Transfer register
    logic              full;     // Transfer register holds a word
    logic [XW-1:0]     shreg;    // Serialiser
    logic [5:0]        left;     // Chunks still to move
    tiop_phase_t       ph;       // Transfer phase
    logic [XW-1:0]     cond;     // Compare value
    logic [CW-1:0]     tgt;      // Counter target
    logic              timed;    // Target armed
    logic [CW-1:0]     count;    // Port counter
    logic [CW-1:0]     stamp;    // Timestamp
    logic [XW-1:0]     drive;    // Value on output pins
    logic              strobe;   // Outgoing strobe pulse
    logic              event_p;  // Event pulse
  } tiop_port_t;

  typedef struct packed {
    tiop_port_t [NPORT-1:0]      port;
    logic [NPIN-1:0]             link;     // Pins taken by the link
    logic [NCLKB-1:0][CW-1:0]    cb;       // Clock block settings
    logic [NPIN-1:0]             pin_s1;   // Pin synchroniser, stage 1
    logic [NPIN-1:0]             pin_s2;   // Pin synchroniser, stage 2
    logic [NPORT-1:0]            stb_s1;   // Strobe synchroniser, stage 1
    logic [NPORT-1:0]            stb_s2;   // Strobe synchroniser, stage 2
    logic                        dp_wr;    // Write data phase pending
    logic [8:0]                  dp_addr;  // Address of that write
    logic [XW-1:0]               rdata;    // Read data register
  } tiop_state_t;

  tiop_state_t          st;       // Current state
  tiop_state_t          next_st;  // Next state
  logic [NCLKB-1:0]     tick;     // Clock block pulses
  logic [NPIN-1:0]      owned;    // Pin has an enabled owner
  logic [NPIN-1:0][2:0] owner;    // Owning port per pin

  // Decode used by the read path and the write path
  function automatic logic [1:0] map_kind(input logic [8:0] ad);
    map_kind = KIND_NONE;
    if (!ad[GLB_BIT] && (ad[7:5] < 3'(NPORT)))
      map_kind = KIND_PORT;
    else if (ad[8:2] == ADDR_LINK[8:2])
      map_kind = KIND_LINK;
    else if ((ad[8:5] == ADDR_CLKB[8:5]) && (ad[4:2] < 3'(NCLKB)))
      map_kind = KIND_CLKB;
  endfunction

  // ----------------------------------------------------------
  // Clock blocks
  // ----------------------------------------------------------
  // Block 0 is locked to the reference; the rest take edges from
  // the 1-bit port pin, already through the pin synchroniser
  for (genvar g = 0; g < NCLKB; g++)
  begin : g_cb
    tiop_clkblk #(
      .FIXED_REF (g == 0)
    ) i_tiop_clkblk (
      .i_clk     (i_clk),
      .i_rst     (i_rst),
      .i_use_ext (st.cb[g][CB_EXT]),
      .i_div     (st.cb[g][CB_DIV +: CB_DIV_W]),
      .i_ext_lvl (st.pin_s2[0]),
      .o_tick    (tick[g])
    );
  end

  // ----------------------------------------------------------
  // Pin ownership
  // ----------------------------------------------------------
  // Widest first so that a narrower enabled port overwrites it
  always_comb
  begin
    owned = '0;
    owner = '0;
    for (int p = 0; p < NPIN; p++)
      for (int i = NPORT - 1; i >= 0; i--)
        if (!st.link[p] && st.port[i].ctrl[CTRL_EN] && (p < port_w(i)))
        begin
          owned[p] = 1'b1;
          owner[p] = 3'(i);
        end
  end

  // Pin drivers; open drain never drives high
  always_comb
  begin
    logic dbit;
    dbit      = 1'b0;
    o_pin_out = '0;
    o_pin_oe  = '0;
    for (int p = 0; p < NPIN; p++)
      if (owned[p] && st.port[owner[p]].ctrl[CTRL_OUT])
      begin
        dbit = st.port[owner[p]].drive[p];
        if (st.port[owner[p]].ctrl[CTRL_OD])
          o_pin_oe[p] = !dbit;
        else
        begin
          o_pin_oe[p]  = 1'b1;
          o_pin_out[p] = dbit;
        end
      end
  end

  // Pull-downs on in reset and on any pin nobody owns
  assign o_pin_pulldown = {NPIN{i_rst}} | ~owned;

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  always_comb
  begin
    logic            acc;
    logic            out;
    logic            cok;
    logic            go;
    logic [2:0]      sel;
    logic            t;
    logic [XW-1:0]   pin_i;
    logic [XW-1:0]   sh;
    logic [XW-1:0]   rd;
    tiop_port_t      pr;
    acc     = i_hsel && i_hready && i_htrans[1];
    out     = 1'b0;
    cok     = 1'b0;
    go      = 1'b0;
    sel     = 3'h0;
    t       = 1'b0;
    pin_i   = '0;
    sh      = '0;
    rd      = '0;
    pr      = '0;
    next_st = st;
    // Synchronisers
    next_st.pin_s1 = i_pin_in;
    next_st.pin_s2 = st.pin_s1;
    next_st.stb_s1 = i_strobe_in;
    next_st.stb_s2 = st.stb_s1;
    // Address phase; unmapped or high addresses fall to no-op
    next_st.dp_wr   = acc && i_hwrite && (i_haddr[31:9] == 23'h0);
    next_st.dp_addr = i_haddr[8:0];
    if (acc && !i_hwrite)
    begin
      // High address bits set read back as zero, never stale data
      case ((i_haddr[31:9] == 23'h0) ? map_kind(i_haddr[8:0]) : KIND_NONE)
        KIND_PORT:
        begin
          pr = st.port[i_haddr[7:5]];
          case (i_haddr[4:2])
            REG_CTRL:  rd = {20'h0_0000, pr.ctrl};
            REG_DATA:
            begin
              rd = pr.xfer;
              // Reading an input word frees the transfer register
              if (!pr.ctrl[CTRL_OUT])
                next_st.port[i_haddr[7:5]].full = 1'b0;
            end
            REG_COND:  rd = pr.cond;
            REG_TIME:  rd = {16'h0000, pr.tgt};
            REG_COUNT: rd = {16'h0000, pr.count};
            REG_STAMP: rd = {16'h0000, pr.stamp};
            REG_STAT:  rd = {30'h0000_0000, pr.ph != PH_IDLE, pr.full};
            default:   rd = '0;
          endcase
        end
        KIND_LINK: rd = st.link;
        KIND_CLKB: rd = {16'h0000, st.cb[i_haddr[4:2]]};
        default:   rd = '0;
      endcase
      next_st.rdata = rd;
    end
    // Port engines; hardware sets come after the read clear
    for (int i = 0; i < NPORT; i++)
    begin
      pin_i = '0;
      for (int p = 0; p < NPIN; p++)
        if (owned[p] && (owner[p] == 3'(i)))
          pin_i[p] = st.pin_s2[p];
      out = st.port[i].ctrl[CTRL_OUT];
      sel = st.port[i].ctrl[CTRL_CLK +: 3];
      t   = (sel < 3'(NCLKB)) ? tick[sel] : 1'b0;
      next_st.port[i].strobe  = 1'b0;
      next_st.port[i].event_p = 1'b0;
      if (t)
        next_st.port[i].count = st.port[i].count + 16'h0001;
      // Sample condition on the masked pin value
      case (tiop_cond_t'(st.port[i].ctrl[CTRL_COND +: 2]))
        COND_EQ:  cok = (pin_i & port_mask(i)) == (st.port[i].cond & port_mask(i));
        COND_NEQ: cok = (pin_i & port_mask(i)) != (st.port[i].cond & port_mask(i));
        default:  cok = 1'b1;
      endcase
      // Condition and target gate only the first chunk
      go = t && (out || !st.port[i].ctrl[CTRL_STB] || st.stb_s2[i])
             && ((st.port[i].ph == PH_SHIFT)
                 || ((!st.port[i].timed || (st.port[i].count == st.port[i].tgt))
                     && (out || cok)));
      // Missing pins read as zero but still fill a full chunk
      sh = (st.port[i].shreg >> port_w(i)) | (out ? '0 : (pin_i << (XW - port_w(i))));
      if (!st.port[i].ctrl[CTRL_EN])
        next_st.port[i].ph = PH_IDLE;
      else
        case (st.port[i].ph)
          PH_IDLE:
          begin
            if (!out || st.port[i].full)
            begin
              next_st.port[i].ph    = PH_WAIT;
              next_st.port[i].left  = port_chunks(i);
              next_st.port[i].shreg = out ? st.port[i].xfer : '0;
              if (out)
                next_st.port[i].full = 1'b0;
            end
          end
          PH_WAIT, PH_SHIFT:
          begin
            if (go)
            begin
              next_st.port[i].ph    = PH_SHIFT;
              next_st.port[i].shreg = sh;
              next_st.port[i].left  = st.port[i].left - 6'h01;
              if (st.port[i].ph == PH_WAIT)
              begin
                next_st.port[i].stamp = st.port[i].count;
                next_st.port[i].timed = 1'b0;
              end
              if (out)
              begin
                next_st.port[i].drive  = st.port[i].shreg & port_mask(i);
                next_st.port[i].strobe = 1'b1;
              end
              if (st.port[i].left == 6'h01)
              begin
                next_st.port[i].ph      = PH_IDLE;
                next_st.port[i].event_p = 1'b1;
                if (!out)
                begin
                  next_st.port[i].xfer = sh;
                  next_st.port[i].full = 1'b1;
                end
              end
            end
          end
          default: next_st.port[i].ph = PH_IDLE;
        endcase
    end
    // Write data phase; a core write wins over the engine
    if (st.dp_wr)
    begin
      case (map_kind(st.dp_addr))
        KIND_PORT:
          case (st.dp_addr[4:2])
            REG_CTRL: next_st.port[st.dp_addr[7:5]].ctrl = i_hwdata[CTRL_W-1:0];
            REG_DATA:
            begin
              next_st.port[st.dp_addr[7:5]].xfer = i_hwdata;
              next_st.port[st.dp_addr[7:5]].full = 1'b1;
            end
            REG_COND: next_st.port[st.dp_addr[7:5]].cond = i_hwdata;
            REG_TIME:
            begin
              next_st.port[st.dp_addr[7:5]].tgt   = i_hwdata[CW-1:0];
              next_st.port[st.dp_addr[7:5]].timed = 1'b1;
            end
            default: ;
          endcase
        KIND_LINK: next_st.link = i_hwdata;
        KIND_CLKB: next_st.cb[st.dp_addr[4:2]] = i_hwdata[CW-1:0];
        default: ;
      endcase
    end
  end

  // State register; zero reset puts every port on block 0
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      st <= '0;
    else
      st <= next_st;
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = st.rdata;

  always_comb
  begin
    for (int i = 0; i < NPORT; i++)
    begin
      o_strobe_out[i] = st.port[i].strobe;
      o_event[i]      = st.port[i].event_p;
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb_main @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  property p_zero_wait;
    o_hreadyout && !o_hresp;
  endproperty
  a_zero_wait:
    assert property (p_zero_wait) else $error("Slave stalled or erred");

  property p_clk0_after_reset;
    $past(i_rst) |-> (st.port[0].ctrl[CTRL_CLK +: 3] == 3'h0) && (st.port[4].ctrl[CTRL_CLK +: 3] == 3'h0);
  endproperty
  a_clk0_after_reset:
    assert property (p_clk0_after_reset) else $error("Port not on clock block 0");

  property p_count_step;
    (tick[0] && (st.port[4].ctrl[CTRL_CLK +: 3] == 3'h0)) |=> (st.port[4].count == $past(st.port[4].count) + 16'h0001);
  endproperty
  a_count_step:
    assert property (p_count_step) else $error("Counter did not step");

  property p_od_low;
    (st.port[4].ctrl[CTRL_EN] && st.port[4].ctrl[CTRL_OUT] && st.port[4].ctrl[CTRL_OD] && !st.link[31])
      |-> !o_pin_out[31] && (o_pin_oe[31] == !st.port[4].drive[31]);
  endproperty
  a_od_low:
    assert property (p_od_low) else $error("Open drain drove wrongly");

  property p_link_off;
    (st.link & o_pin_oe) == '0;
  endproperty
  a_link_off:
    assert property (p_link_off) else $error("Link pin driven by a port");

  property p_narrow_wins;
    (st.port[0].ctrl[CTRL_EN] && !st.port[0].ctrl[CTRL_OUT] && !st.link[0]) |-> !o_pin_oe[0];
  endproperty
  a_narrow_wins:
    assert property (p_narrow_wins) else $error("Wider port drove a taken pin");

  property p_wide_keeps;
    (st.port[4].ctrl[CTRL_EN] && st.port[4].ctrl[CTRL_OUT] && !st.port[4].ctrl[CTRL_OD]
      && st.port[0].ctrl[CTRL_EN] && !st.link[31]) |-> o_pin_oe[31];
  endproperty
  a_wide_keeps:
    assert property (p_wide_keeps) else $error("Unshared pin lost");

  property p_stamp;
    st.port[4].event_p |-> (st.port[4].stamp == $past(st.port[4].count));
  endproperty
  a_stamp:
    assert property (p_stamp) else $error("Timestamp wrong");

  property p_count_read;
    (i_hsel && i_hready && i_htrans[1] && !i_hwrite && (i_haddr == {24'h00_0000, 3'h4, REG_COUNT, 2'h0}))
      |=> (o_hrdata == {16'h0000, $past(st.port[4].count)});
  endproperty
  a_count_read:
    assert property (p_count_read) else $error("Counter read wrong");
endmodule

// [tb/tiop_pins.sv]
// Far-side model: external hardware on the pins
`timescale 1ns/1ns
module tiop_pins
  import tiop_pkg::*;
(
  // Device side
  input  wire logic [NPIN-1:0]  i_out,
  input  wire logic [NPIN-1:0]  i_oe,
  input  wire logic [NPIN-1:0]  i_pd,
  // Bench control
  input  wire logic [NPIN-1:0]  i_drv,
  input  wire logic [NPIN-1:0]  i_drv_en,
  input  wire logic [NPORT-1:0] i_stb,
  // Levels seen by the device
  output logic [NPIN-1:0]       o_pin,
  output logic [NPORT-1:0]      o_stb
);
  // Device wins; released line floats high unless pulled down
  assign o_pin = (i_oe & i_out) | (~i_oe & i_drv_en & i_drv) | (~i_oe & ~i_drv_en & ~i_pd);
  // Strobes qualify data from this side
  assign o_stb = i_stb;
endmodule

// [tb/tb.sv]
// Bench for the timed I/O port unit
`timescale 1ns/1ns
module tb;
  import tiop_pkg::*;
  logic             i_clk = 0, i_rst = 1, hsel = 0, hwrite = 0;
  logic [1:0]       htrans = 0;
  logic [2:0]       hsize = 3'h2;
  logic [31:0]      haddr = 0, hwdata = 0, hrdata, r, a;
  logic             hready, hresp;
  logic [NPIN-1:0]  pin, pout, poe, ppd, drv = 0, drv_en = 0;
  logic [NPORT-1:0] stb = 0, stb_s, sout, ev;
  int               err_total = 0, samples_checked = 0, cyc = 0;
  always #5 i_clk = ~i_clk;
  tiop_top i_tiop_top (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
    .o_hresp(hresp), .o_hrdata(hrdata), .i_pin_in(pin), .o_pin_out(pout), .o_pin_oe(poe),
    .o_pin_pulldown(ppd), .i_strobe_in(stb_s), .o_strobe_out(sout), .o_event(ev));
  tiop_pins i_tiop_pins (.i_out(pout), .i_oe(poe), .i_pd(ppd), .i_drv(drv), .i_drv_en(drv_en),
    .i_stb(stb), .o_pin(pin), .o_stb(stb_s));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic give_verdict();
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Single AHB transfer; waits on hready with no timeout of its own, the hang guard ends a hang
  task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
    @(posedge i_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    do @(posedge i_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk); while (hready !== 1'b1);
    r = hrdata;
    chk(32'(hresp), 32'h0);
  endtask
  // Bounded wait for an event (s=0) or strobe_out (s=1) pulse
  task automatic wait_hi(input bit s, input int k);
    int n;
    n = 0;
    do
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    while ((s ? sout[k] : ev[k]) !== 1'b1 && n < 300);
    chk(32'(n < 300), 32'h1);
  endtask
  // Hang guard
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      err_total++;
      give_verdict();
    end
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge i_clk);
    chk(ppd, 32'hFFFF_FFFF);
    chk(poe, 32'h0);
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    // Every port starts on clock block 0
    for (int i = 0; i < 5; i++)
    begin
      bus(0, 32'(32 * i), 0);
      chk(r, 32'h0);
    end
    // Wide output word goes out whole, with strobe and event
    bus(1, 32'h80, 32'h3);
    bus(1, 32'h84, 32'hA5A5_1234);
    wait_hi(0, 4);
    chk(pin, 32'hA5A5_1234);
    chk(32'(sout[4]), 32'h1);
    // Narrow open-drain port overrides low pins only
    bus(1, 32'h20, 32'h7);
    bus(1, 32'h24, 32'hA);
    wait_hi(1, 1);
    chk(poe, 32'hFFFF_FFF5);
    chk(pout & 32'hF, 32'h0);
    chk(pin, 32'hA5A5_123A);
    bus(1, 32'h20, 32'h0);
    bus(1, 32'h80, 32'h0);
    // Input waits for pins equal to the value, then takes two chunks
    drv <= 32'h4321;
    drv_en <= '1;
    bus(1, 32'h68, 32'h1234);
    bus(1, 32'h60, 32'h101);
    repeat (20) @(posedge i_clk);
    bus(0, 32'h78, 0);
    chk(r & 32'h1, 32'h0);
    drv <= 32'h1234;
    wait_hi(0, 3);
    bus(0, 32'h64, 0);
    chk(r, 32'h1234_1234);
    // Address above the map reads zero after a nonzero read
    bus(0, 32'h0000_0200, 0);
    chk(r, 32'h0);
    // Counter readable, one step per reference tick
    bus(0, 32'h70, 0);
    a = r;
    bus(0, 32'h70, 0);
    chk((r - a) & 32'hFFFF, 32'h3);
    // Output word held until the counter meets its target, stamped there
    bus(1, 32'h60, 32'h0);
    bus(0, 32'h90, 0);
    a = (r + 32'h28) & 32'hFFFF;
    bus(1, 32'h80, 32'h3);
    bus(1, 32'h8C, a);
    bus(1, 32'h84, 32'h5A5A_0F0F);
    wait_hi(0, 4);
    chk(pin, 32'h5A5A_0F0F);
    bus(0, 32'h94, 0);
    chk(r, a);
    // Link takes pin 0 away from the ports
    bus(1, 32'h100, 32'h1);
    @(negedge i_clk);
    chk(poe, 32'hFFFF_FFFE);
    // Strobe-qualified input waits for the strobe; pin 0 reads zero
    bus(1, 32'h40, 32'h801);
    drv <= 32'h0000_00AB;
    repeat (20) @(posedge i_clk);
    bus(0, 32'h58, 0);
    chk(r & 32'h3, 32'h2);
    stb <= 5'h04;
    wait_hi(0, 2);
    bus(0, 32'h44, 0);
    chk(r, 32'hAAAA_AAAA);
    give_verdict();
  end
endmodule
